//--- rtl/ext_decode_pkg.sv
/*
  Shared constants for the escape-prefixed instruction decoder.
  Assumes a single core clock and a core that fetches one byte per cycle.
*/
package ext_decode_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ESCAPE     = 8'ha5;
  localparam logic [7:0] OP_BREAK      = 8'h00;
  localparam logic [7:0] OP_ASR_M      = 8'h03;
  localparam logic [7:0] OP_CLR_M      = 8'he4;
  localparam logic [7:0] OP_MAC_AB     = 8'ha4;
  localparam logic [7:0] OP_CMP_R0     = 8'hb6;
  localparam logic [7:0] OP_CMP_R1     = 8'hb7;
  localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_RD    = 8'he0;
  localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_WR    = 8'hf0;
  localparam logic [7:0] OP_PUSH       = 8'hc0;
  localparam logic [7:0] OP_POP        = 8'hd0;
  localparam logic [7:0] OP_LCALL      = 8'h12;
  localparam logic [7:0] OP_RET        = 8'h22;
  localparam logic [7:0] OP_RETI       = 8'h32;
  localparam logic [7:0] OP_ACALL_MASK = 8'h1f;
  localparam logic [7:0] OP_ACALL_LOW  = 8'h11;
  localparam logic [7:0] OP_CMP_IND_LO = 8'hb6;
  localparam logic [7:0] OP_CMP_IND_HI = 8'hb7;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int          MAC_W        = 40;
  localparam int          MAC_SIGN_BIT = 39;
  localparam int          PROD_W       = 32;
  localparam int          OPND_W       = 16;
  localparam logic [39:0] MAC_RESET    = 40'h00_0000_0000;

  // ---------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------
  localparam logic [3:0] CYC_BREAK      = 4'h2;
  localparam logic [3:0] CYC_ASR        = 4'h2;
  localparam logic [3:0] CYC_CLR        = 4'h2;
  localparam logic [3:0] CYC_MAC        = 4'h9;
  localparam logic [3:0] CYC_CMP        = 4'h4;
  localparam logic [3:0] CYC_EXTERNAL_DATA_MOVE_EXTRA_RAM  = 4'h2;
  localparam logic [3:0] CYC_EXTERNAL_DATA_MOVE_OTHER = 4'h4;
  localparam logic [3:0] CYC_EXTERNAL_DATA_MOVE_ALT_E = 4'h3;
  localparam logic [3:0] CYC_EXTERNAL_DATA_MOVE_ALT_O = 4'h5;
  localparam logic [3:0] CYC_PUSH       = 4'h2;
  localparam logic [3:0] CYC_PUSH_EXT   = 4'h3;
  localparam logic [3:0] CYC_ACALL      = 4'h3;
  localparam logic [3:0] CYC_ACALL_EXT  = 4'h5;
  localparam logic [3:0] CYC_LCALL      = 4'h4;
  localparam logic [3:0] CYC_LCALL_EXT  = 4'h6;
  localparam logic [3:0] CYC_RET        = 4'h4;
  localparam logic [3:0] CYC_RET_EXT    = 4'h5;
  localparam logic [3:0] CYC_CMP_IMM    = 4'h4;
  localparam logic [3:0] CYC_DEFAULT    = 4'h1;

  // ---------------------------------------------------------------
  // Lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [2:0] LEN_ESC_CMP  = 3'h3;
  localparam logic [2:0] LEN_ESC_TWO  = 3'h2;
  localparam logic [2:0] LEN_CMP_IMM  = 3'h3;
  localparam logic [2:0] LEN_ONE      = 3'h1;
  localparam logic [2:0] LEN_TWO      = 3'h2;
  localparam logic [2:0] LEN_THREE    = 3'h3;

  // Data spaces reached by an external-data move.
  typedef enum logic [1:0] {
    SPACE_EXTRA_RAM = 2'h0,
    SPACE_FLASH     = 2'h1,
    SPACE_EXTERNAL  = 2'h2,
    SPACE_CODE      = 2'h3
  } space_t;

  // Extended operation selected by the byte after the escape.
  typedef enum logic [3:0] {
    XOP_NONE   = 4'h0,
    XOP_BREAK  = 4'h1,
    XOP_ASR    = 4'h2,
    XOP_CLR    = 4'h3,
    XOP_CMP    = 4'h4,
    XOP_EXTERNAL_DATA_MOVE   = 4'h5,
    XOP_MAC    = 4'h6,
    XOP_OTHER  = 4'h7
  } xop_t;

endpackage : ext_decode_pkg

//--- rtl/mac_accum.sv
/*
  Forty-bit multiply-accumulate register with shift and clear.
  Assumes the decoder raises at most one operation strobe per cycle.
*/
module mac_accum
  import ext_decode_pkg::*;
#(
  parameter int ACC_W = MAC_W
) (
  input  wire logic                     clk,       // Core clock.
  input  wire logic                     rst_n,     // Sync reset.
  input  wire logic                     ce,        // Clock enable.
  input  wire logic                     do_acc,    // Add product.
  input  wire logic                     do_asr,    // Shift right.
  input  wire logic                     do_clr,    // Clear to zero.
  input  wire logic signed [OPND_W-1:0] opnd_a,    // First operand.
  input  wire logic signed [OPND_W-1:0] opnd_b,    // Second operand.
  output logic             [ACC_W-1:0]  acc        // Register value.
);

  // ---------------------------------------------------------------
  // Next value
  // ---------------------------------------------------------------
  logic               [ACC_W-1:0]  next_acc;
  logic signed        [PROD_W-1:0] product;

  always_comb begin
    product  = opnd_a * opnd_b;
    next_acc = acc;
    if (do_clr) begin
      next_acc = MAC_RESET;
    end else if (do_asr) begin
      next_acc = {acc[ACC_W-1], acc[ACC_W-1:1]};
    end else if (do_acc) begin
      next_acc = acc + {{(ACC_W-PROD_W){product[PROD_W-1]}},
                        product};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= MAC_RESET;
    end else if (ce) begin
      acc <= next_acc;
    end
  end

endmodule : mac_accum

//--- rtl/ext_decode.sv
/*
  Decoder and cycle timer for escape-prefixed extended instructions,
  external-data moves, stack instructions and compare-branches.
  Assumes the core presents one fetched byte per cycle on fetch_byte
  with fetch_valid, and supplies operands, flags and data-space target.
*/
// Function
// - Escape byte A5 prefixes every extension; next byte picks operation.
// - Arithmetic shift right of 40-bit register keeps bit 39, no flags.
// - Break with debug enabled enters debug handler, PC at next.
// - Break with debug disabled is a two-byte two-cycle no-op.
// - Extended compare branches when A differs from @Ri; PC-relative target.
// - Carry set when A unsigned below @Ri; operands untouched.
// - Clear of 40-bit register zeroes it in two cycles, no flags.
// - Pointer move: two cycles to extra RAM, four elsewhere.
// - Alternate-pointer move: three cycles extra RAM, five elsewhere.
// - Stack instructions take longer count when extended stack used.
// - Indirect compare with immediate is three bytes, four cycles.
// - Alternate pointer is the one the select bit does not choose.
// - The 40-bit register accumulates signed 16x16 product.
module ext_decode
  import ext_decode_pkg::*;
(
  input  wire logic        clk,            // Core clock, 20 MHz.
  input  wire logic        rst_n,          // Sync reset, active low.
  input  wire logic        ce,             // Clock enable.
  input  wire logic        fetch_valid,    // Fetch byte present.
  input  wire logic [7:0]  fetch_byte,     // Fetched byte.
  input  wire logic [15:0] pc_in,          // Address of opcode byte.
  input  wire logic        debug_enable,   // On-chip debug allowed.
  input  wire logic        ext_stack,      // Extended stack in use.
  input  wire logic        pointer_select, // Pointer select bit.
  input  wire logic [15:0] data_pointer0,  // Data pointer 0.
  input  wire logic [15:0] data_pointer1,  // Data pointer 1.
  input  wire logic [1:0]  external_data_move_space,     // Target space of move.
  input  wire logic [7:0]  acc_in,         // Accumulator.
  input  wire logic [7:0]  ind_ram,        // Byte at @Ri.
  input  wire logic [7:0]  acc_x,          // High operand byte A.
  input  wire logic [7:0]  b_in,           // B register.
  input  wire logic [7:0]  b_x,            // High operand byte B.
  input  wire logic        carry_in,       // Current carry.
  output logic             busy,           // Instruction executing.
  output logic             done,           // Last cycle pulse.
  output logic [3:0]       cycles,         // Cycle count of instr.
  output logic [2:0]       length,         // Length in bytes.
  output logic             branch,         // Branch taken pulse.
  output logic [15:0]      branch_target,  // Branch address.
  output logic             carry_out,      // Carry after instr.
  output logic             debug_enter,    // Debug handler entry.
  output logic [15:0]      debug_pc,       // Resume address.
  output logic [15:0]      external_data_move_addr,      // External move address.
  output logic [39:0]      mac_value       // Multiply-accumulate.
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] pick(input logic sel,
                                      input logic [3:0] lo,
                                      input logic [3:0] hi);
    pick = sel ? hi : lo;
  endfunction : pick

  function automatic logic is_acall(input logic [7:0] op);
    is_acall = (op & OP_ACALL_MASK) == OP_ACALL_LOW;
  endfunction : is_acall

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OPCODE = 5'b00001,
    ST_EXTOP  = 5'b00010,
    ST_OPND   = 5'b00100,
    ST_EXEC   = 5'b01000,
    ST_DONE   = 5'b10000
  } state_t;

  state_t     state;
  state_t     next_state;
  xop_t       xop;
  xop_t       next_xop;
  logic [3:0] count;
  logic [3:0] next_count;
  logic [1:0] need;
  logic [1:0] next_need;
  logic [15:0] base_pc;
  logic [15:0] next_base_pc;
  logic        escaped;
  logic        next_escaped;
  logic        next_busy;
  logic        next_done;
  logic [3:0]  next_cycles;
  logic [2:0]  next_length;
  logic        next_branch;
  logic [15:0] next_branch_target;
  logic        next_carry_out;
  logic        next_debug_enter;
  logic [15:0] next_debug_pc;
  logic [15:0] next_external_data_move_addr;
  logic        mac_acc;
  logic        mac_asr;
  logic        mac_clr;
  logic [15:0] alt_ptr;
  logic [15:0] cur_ptr;
  logic        other_space;

  always_comb begin
    alt_ptr     = pointer_select ? data_pointer0 : data_pointer1;
    cur_ptr     = pointer_select ? data_pointer1 : data_pointer0;
    other_space = external_data_move_space != SPACE_EXTRA_RAM;
  end

  always_comb begin
    next_state         = state;
    next_xop           = xop;
    next_count         = count;
    next_need          = need;
    next_base_pc       = base_pc;
    next_escaped       = escaped;
    next_busy          = busy;
    next_done          = 1'b0;
    next_cycles        = cycles;
    next_length        = length;
    next_branch        = 1'b0;
    next_branch_target = branch_target;
    next_carry_out     = carry_out;
    next_debug_enter   = 1'b0;
    next_debug_pc      = debug_pc;
    next_external_data_move_addr     = external_data_move_addr;
    mac_acc            = 1'b0;
    mac_asr            = 1'b0;
    mac_clr            = 1'b0;
    unique case (state)
      ST_OPCODE: begin
        if (fetch_valid) begin
          next_base_pc = pc_in;
          next_busy    = 1'b1;
          next_escaped = 1'b0;
          next_xop     = XOP_NONE;
          next_need    = 2'd0;
          next_state   = ST_EXEC;
          next_length  = LEN_ONE;
          next_cycles  = CYC_DEFAULT;
          if (fetch_byte == OP_ESCAPE) begin
            next_escaped = 1'b1;
            next_state   = ST_EXTOP;
          end else if (fetch_byte == OP_EXTERNAL_DATA_MOVE_RD ||
                       fetch_byte == OP_EXTERNAL_DATA_MOVE_WR) begin
            next_cycles    = pick(other_space, CYC_EXTERNAL_DATA_MOVE_EXTRA_RAM,
                                  CYC_EXTERNAL_DATA_MOVE_OTHER);
            next_external_data_move_addr = cur_ptr;
          end else if (fetch_byte == OP_PUSH ||
                       fetch_byte == OP_POP) begin
            next_length = LEN_TWO;
            next_cycles = pick(ext_stack, CYC_PUSH,
                               CYC_PUSH_EXT);
          end else if (is_acall(fetch_byte)) begin
            next_length = LEN_TWO;
            next_cycles = pick(ext_stack, CYC_ACALL,
                               CYC_ACALL_EXT);
          end else if (fetch_byte == OP_LCALL) begin
            next_length = LEN_THREE;
            next_cycles = pick(ext_stack, CYC_LCALL,
                               CYC_LCALL_EXT);
          end else if (fetch_byte == OP_RET ||
                       fetch_byte == OP_RETI) begin
            next_cycles = pick(ext_stack, CYC_RET,
                               CYC_RET_EXT);
          end else if (fetch_byte == OP_CMP_IND_LO ||
                       fetch_byte == OP_CMP_IND_HI) begin
            next_length = LEN_CMP_IMM;
            next_cycles = CYC_CMP_IMM;
          end
          next_count = next_cycles;
        end
      end
      ST_EXTOP: begin
        if (fetch_valid) begin
          next_state  = ST_EXEC;
          next_length = LEN_ESC_TWO;
          unique case (fetch_byte)
            OP_BREAK: begin
              next_xop    = XOP_BREAK;
              next_cycles = CYC_BREAK;
            end
            OP_ASR_M: begin
              next_xop    = XOP_ASR;
              next_cycles = CYC_ASR;
            end
            OP_CLR_M: begin
              next_xop    = XOP_CLR;
              next_cycles = CYC_CLR;
            end
            OP_MAC_AB: begin
              next_xop    = XOP_MAC;
              next_cycles = CYC_MAC;
            end
            OP_CMP_R0, OP_CMP_R1: begin
              next_xop    = XOP_CMP;
              next_length = LEN_ESC_CMP;
              next_cycles = CYC_CMP;
              next_need   = 2'd1;
              next_state  = ST_OPND;
            end
            OP_EXTERNAL_DATA_MOVE_RD, OP_EXTERNAL_DATA_MOVE_WR: begin
              next_xop       = XOP_EXTERNAL_DATA_MOVE;
              next_cycles    = pick(other_space, CYC_EXTERNAL_DATA_MOVE_ALT_E,
                                    CYC_EXTERNAL_DATA_MOVE_ALT_O);
              next_external_data_move_addr = alt_ptr;
            end
            default: begin
              next_xop    = XOP_OTHER;
              next_cycles = CYC_DEFAULT + 4'h1;
            end
          endcase
          // The escape byte's own cycle is already spent.
          next_count = next_cycles - 4'h1;
        end
      end
      ST_OPND: begin
        if (fetch_valid) begin
          // Last byte is the signed displacement from the next PC.
          next_branch_target = base_pc + 16'(length)
                             + {{8{fetch_byte[7]}}, fetch_byte};
          next_count = count - 4'h1;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (count <= 4'h1) begin
          next_state = ST_DONE;
          unique case (xop)
            XOP_ASR:  mac_asr = 1'b1;
            XOP_CLR:  mac_clr = 1'b1;
            XOP_MAC:  mac_acc = 1'b1;
            XOP_BREAK: begin
              next_debug_enter = debug_enable;
              next_debug_pc    = base_pc + 16'(length);
            end
            XOP_CMP: begin
              next_branch    = acc_in != ind_ram;
              next_carry_out = acc_in < ind_ram;
            end
            default: next_carry_out = carry_in;
          endcase
          if (xop != XOP_CMP) begin
            next_carry_out = carry_in;
          end
        end else begin
          next_count = count - 4'h1;
        end
      end
      ST_DONE: begin
        next_done  = 1'b1;
        next_busy  = 1'b0;
        next_state = ST_OPCODE;
      end
      default: next_state = ST_OPCODE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= ST_OPCODE;
      xop           <= XOP_NONE;
      count         <= 4'h0;
      need          <= 2'd0;
      base_pc       <= 16'h0000;
      escaped       <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      cycles        <= 4'h0;
      length        <= 3'h0;
      branch        <= 1'b0;
      branch_target <= 16'h0000;
      carry_out     <= 1'b0;
      debug_enter   <= 1'b0;
      debug_pc      <= 16'h0000;
      external_data_move_addr     <= 16'h0000;
    end else if (ce) begin
      state         <= next_state;
      xop           <= next_xop;
      count         <= next_count;
      need          <= next_need;
      base_pc       <= next_base_pc;
      escaped       <= next_escaped;
      busy          <= next_busy;
      done          <= next_done;
      cycles        <= next_cycles;
      length        <= next_length;
      branch        <= next_branch;
      branch_target <= next_branch_target;
      carry_out     <= next_carry_out;
      debug_enter   <= next_debug_enter;
      debug_pc      <= next_debug_pc;
      external_data_move_addr     <= next_external_data_move_addr;
    end
  end

  // ---------------------------------------------------------------
  // Multiply-accumulate register
  // ---------------------------------------------------------------
  mac_accum #(
    .ACC_W (MAC_W)
  ) u_mac (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .do_acc (mac_acc),
    .do_asr (mac_asr),
    .do_clr (mac_clr),
    .opnd_a ({acc_x, acc_in}),
    .opnd_b ({b_x, b_in}),
    .acc    (mac_value)
  );

endmodule : ext_decode

//--- verification/ext_decode_sva.sv
/*
  Concurrent checks on the ports of the extended-opcode decoder.
  Assumes one core clock, a synchronous active-low reset and ce high.
*/
module ext_decode_sva
  import ext_decode_pkg::*;
(
  input wire logic        clk,          // Core clock.
  input wire logic        rst_n,        // Sync reset.
  input wire logic        ce,           // Clock enable.
  input wire logic        fetch_valid,  // Byte present.
  input wire logic [7:0]  fetch_byte,   // Fetched byte.
  input wire logic        debug_enable, // Debug allowed.
  input wire logic        carry_in,     // Current carry.
  input wire logic        busy,         // Executing.
  input wire logic        done,         // End pulse.
  input wire logic [3:0]  cycles,       // Cycle count.
  input wire logic [2:0]  length,       // Byte length.
  input wire logic        branch,       // Branch pulse.
  input wire logic        carry_out,    // Carry after.
  input wire logic        debug_enter,  // Debug entry.
  input wire logic [39:0] mac_value     // Accumulator.
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_done_busy; done |-> !busy && $past(busy); endproperty
  a_done_busy: assert property (p_done_busy)
    else $error("done outside busy");
  property p_idle; (done && ce) |=> !busy; endproperty
  a_idle: assert property (p_idle)
    else $error("busy after done");
  property p_len; done |-> length != 3'h0; endproperty
  a_len: assert property (p_len)
    else $error("zero length at done");

  // ---------------------------------------------------------------
  // Extended operations
  // ---------------------------------------------------------------
  property p_branch; branch |=> done; endproperty
  a_branch: assert property (p_branch)
    else $error("branch pulse apart from done");
  property p_dbg;
    debug_enter |-> $past(debug_enable) ##1 done;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug entry without debug enabled");
  property p_nodbg;
    (ce && fetch_valid && !busy && fetch_byte == 8'ha5 && !debug_enable)
    ##1 (fetch_valid && fetch_byte == 8'h00) |-> ##1 !debug_enter [*4];
  endproperty
  a_nodbg: assert property (p_nodbg)
    else $error("break entered debug while disabled");
  property p_clr;
    (ce && fetch_valid && !busy && fetch_byte == 8'ha5)
    ##1 (fetch_valid && fetch_byte == 8'he4)
    |-> ##[1:4] (done && mac_value == 40'h0 && cycles == 4'h2);
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear did not zero the accumulator");
  property p_mac_hold; $changed(mac_value) |-> $past(busy); endproperty
  a_mac_hold: assert property (p_mac_hold)
    else $error("accumulator changed while idle");
  property p_carry;
    (done && cycles != 4'h4) |-> carry_out == carry_in;
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry changed by a flag-neutral instruction");
endmodule : ext_decode_sva

bind ext_decode ext_decode_sva ext_decode_sva_i (
  .clk(clk), .rst_n(rst_n), .ce(ce), .fetch_valid(fetch_valid),
  .fetch_byte(fetch_byte), .debug_enable(debug_enable),
  .carry_in(carry_in), .busy(busy), .done(done), .cycles(cycles),
  .length(length), .branch(branch), .carry_out(carry_out),
  .debug_enter(debug_enter), .mac_value(mac_value));

//--- verification/mem_model.sv
/*
  Behavioural program memory and indirect RAM for the decoder bench.
  Assumes the bench loads both arrays directly and drives the addresses.
*/
module mem_model (
  input  wire logic        rd_en,     // Fetch in progress.
  input  wire logic [15:0] code_addr, // Code address.
  input  wire logic [7:0]  ram_addr,  // Indirect RAM address.
  output logic      [7:0]  code_byte, // Code byte.
  output logic      [7:0]  ram_byte   // Indirect RAM byte.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] code [0:255];
  logic [7:0] data [0:255];

  // Outside a fetch the bus shows the inverted byte, so a design that
  // samples a stale fetch sees garbage rather than a lucky match.
  assign code_byte = rd_en ? code[code_addr[7:0]] : ~code[code_addr[7:0]];
  assign ram_byte  = data[ram_addr];
endmodule : mem_model

//--- verification/extended_opcode_decode_timing_test.sv
/*
  Self-checking bench for the extended-opcode decoder.
  Assumes the decoder, its package and the memory model are compiled first.
*/
module extended_opcode_decode_timing_test;
  import ext_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, fetch_valid = 1'b0;
  logic        debug_enable = 1'b0, ext_stack = 1'b0, pointer_select = 1'b0;
  logic        carry_in = 1'b1, seen_br, seen_dbg;
  logic [15:0] fetch_addr = 16'h0, pc_in = 16'h0;
  logic [15:0] dp0 = 16'h0123, dp1 = 16'h4567;
  logic [1:0]  external_data_move_space = 2'h0;
  logic [7:0]  acc_in = 8'h03, acc_x = 8'h00, b_in = 8'hfe, b_x = 8'hff;
  logic [7:0]  fetch_byte, ind_ram;
  logic        busy, done, branch, carry_out, debug_enter;
  logic [3:0]  cycles;
  logic [2:0]  length;
  logic [15:0] branch_target, debug_pc, external_data_move_addr;
  logic [39:0] mac_value;
  int          error_cnt = 0, num_checks = 0;

  always #25 clk = ~clk;

  mem_model mem_model_i (.rd_en(fetch_valid), .code_addr(fetch_addr),
    .ram_addr(8'h78), .code_byte(fetch_byte), .ram_byte(ind_ram));

  ext_decode ext_decode_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .pc_in(pc_in),
    .debug_enable(debug_enable), .ext_stack(ext_stack),
    .pointer_select(pointer_select), .data_pointer0(dp0),
    .data_pointer1(dp1), .external_data_move_space(external_data_move_space), .acc_in(acc_in),
    .ind_ram(ind_ram), .acc_x(acc_x), .b_in(b_in), .b_x(b_x),
    .carry_in(carry_in), .busy(busy), .done(done), .cycles(cycles),
    .length(length), .branch(branch), .branch_target(branch_target),
    .carry_out(carry_out), .debug_enter(debug_enter),
    .debug_pc(debug_pc), .external_data_move_addr(external_data_move_addr), .mac_value(mac_value));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Feeds n bytes one per cycle, then waits a bounded time for done and
  // lets one more edge pass so the next opcode follows done legally.
  task automatic run(input logic [15:0] a, input logic [7:0] b0,
                     input logic [7:0] b1, input logic [7:0] b2,
                     input int n);
    int t;
    mem_model_i.code[a[7:0]] = b0;
    mem_model_i.code[a[7:0] + 8'h01] = b1;
    mem_model_i.code[a[7:0] + 8'h02] = b2;
    t = 0;
    seen_br = 1'b0;
    seen_dbg = 1'b0;
    pc_in = a;
    for (int i = 0; i < n; i++) begin
      fetch_addr = a + 16'(i);
      fetch_valid = 1'b1;
      @(posedge clk);
      #2;
    end
    fetch_valid = 1'b0;
    while (done !== 1'b1 && t < 20) begin
      @(posedge clk);
      #2;
      seen_br = seen_br | (branch === 1'b1);
      seen_dbg = seen_dbg | (debug_enter === 1'b1);
      t++;
    end
    check(64'(t < 20), 64'h1);
    @(posedge clk);
    #2;
  endtask : run

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mac();
    run(16'h0010, 8'ha5, 8'ha4, 8'h00, 2);
    check(mac_value, 40'hff_ffff_fffa);
    check(cycles, 4'h9);
    run(16'h0020, 8'ha5, 8'h03, 8'h00, 2);
    check(mac_value, 40'hff_ffff_fffd);
    check(carry_out, carry_in);
    check(length, 3'h2);
    run(16'h0028, 8'ha5, 8'he4, 8'h00, 2);
    check(mac_value, 40'h0);
    check(cycles, 4'h2);
  endtask : t_mac

  task automatic t_break();
    run(16'h0030, 8'ha5, 8'h00, 8'h00, 2);
    check(seen_dbg, 1'b0);
    check({cycles, 1'b0, length}, {4'h2, 1'b0, 3'h2});
    debug_enable = 1'b1;
    run(16'h0040, 8'ha5, 8'h00, 8'h00, 2);
    check(seen_dbg, 1'b1);
    check(debug_pc, 16'h0042);
    debug_enable = 1'b0;
  endtask : t_break

  // Less, equal and greater, with a backward displacement.
  task automatic t_cmp();
    logic [7:0] accs [3] = '{8'h34, 8'h56, 8'h78};
    mem_model_i.data[8'h78] = 8'h56;
    for (int i = 0; i < 3; i++) begin
      acc_in = accs[i];
      run(16'h0050, 8'ha5, (i == 2) ? 8'hb7 : 8'hb6, 8'hf0, 3);
      check(seen_br, 1'(i != 1));
      if (i != 1) check(branch_target, 16'h0043);
      check(carry_out, 1'(i == 0));
      check({cycles, 1'b0, length}, {4'h4, 1'b0, 3'h3});
    end
  endtask : t_cmp

  task automatic t_external_data_move();
    for (int s = 0; s < 4; s++) begin
      external_data_move_space = 2'(s);
      pointer_select = 1'(s);
      run(16'h0060, 8'he0, 8'h00, 8'h00, 1);
      check(cycles, (s == 0) ? 4'h2 : 4'h4);
      check(external_data_move_addr, pointer_select ? dp1 : dp0);
      run(16'h0068, 8'ha5, 8'hf0, 8'h00, 2);
      check(cycles, (s == 0) ? 4'h3 : 4'h5);
      check(external_data_move_addr, pointer_select ? dp0 : dp1);
    end
  endtask : t_external_data_move

  task automatic t_stack();
    logic [7:0] ops [6] = '{8'hc0, 8'hd0, 8'h71, 8'h12, 8'h22, 8'h32};
    logic [3:0] c0 [6] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h4};
    logic [3:0] c1 [6] = '{4'h3, 4'h3, 4'h5, 4'h6, 4'h5, 4'h5};
    for (int e = 0; e < 2; e++) begin
      ext_stack = 1'(e);
      for (int i = 0; i < 6; i++) begin
        run(16'h0070, ops[i], 8'h00, 8'h00, 1);
        check(cycles, (e == 1) ? c1[i] : c0[i]);
      end
    end
    ext_stack = 1'b0;
  endtask : t_stack

  task automatic t_cmp_imm();
    run(16'h0080, 8'hb6, 8'h12, 8'h05, 1);
    check({cycles, 1'b0, length}, {4'h4, 1'b0, 3'h3});
  endtask : t_cmp_imm

  initial begin
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check(mac_value, 40'h0);
    t_mac();
    t_break();
    t_cmp();
    t_external_data_move();
    t_stack();
    t_cmp_imm();
    end_of_test();
  end

  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule : extended_opcode_decode_timing_test
